//--- verilog/itxc_pkg.sv
// Constants, offsets and types for the isochronous transmit context status block
package itxc_pkg;
  localparam int          NCTX        = 8;        // Number of transmit contexts
  localparam int          CTX_W       = 3;        // Context number width
  localparam int          AW          = 12;       // Register byte address width
  localparam int          DW          = 32;       // Register data width
  localparam int          Z_W         = 4;        // Descriptor count field width
  localparam int          CODE_W      = 5;        // Completion status width
  localparam int          SKIP_W      = 3;        // Skipped-cycle counter width
  // Register byte addresses
  localparam logic [11:0] A_INT_STAT  = 12'h080;  // Event status, read
  localparam logic [11:0] A_INT_CLR   = 12'h084;  // Event status, write one to clear
  localparam logic [11:0] A_INT_MASK  = 12'h088;  // Event mask
  localparam logic [11:0] A_CTX_BASE  = 12'h200;  // Context n control set
  localparam logic [11:0] A_CMD_PTR   = 12'h20c;  // Context n command pointer
  localparam logic [11:0] CTX_STRIDE  = 12'h010;  // Bytes between contexts
  // Address fields inside the context window
  localparam int          BLK_LSB     = 7;        // Window select field
  localparam logic [4:0]  CTX_BLK     = 5'h04;    // A_CTX_BASE >> BLK_LSB
  localparam int          CTX_LSB     = 4;        // Context number field
  localparam int          SUB_LSB     = 2;        // Register within a context
  localparam logic [1:0]  SUB_SET     = 2'h0;     // Control set
  localparam logic [1:0]  SUB_CLR     = 2'h1;     // Control clear
  localparam logic [1:0]  SUB_LOAD    = 2'h2;     // Pointer load
  localparam logic [1:0]  SUB_PTR     = 2'h3;     // Command pointer
  // Control word bit positions
  localparam int          B_RUN       = 15;
  localparam int          B_WAKE      = 12;
  localparam int          B_DEAD      = 11;
  localparam int          B_ACT       = 10;
  localparam int          B_FATAL     = 24;       // Event status fatal flag
  localparam logic [31:0] INT_DEF     = 32'h0100_00ff; // Implemented event bits
  // Completion status codes
  localparam logic [4:0]  ACK_COMPLETE = 5'h11;
  localparam logic [4:0]  EVT_DESC_RD  = 5'h06;
  localparam logic [4:0]  EVT_DATA_RD  = 5'h07;
  localparam logic [4:0]  EVT_TIMEOUT  = 5'h0a;
  localparam logic [4:0]  EVT_UNKNOWN  = 5'h0e;
  localparam logic [2:0]  SKIP_MAX     = 3'h7;    // Skips tolerated
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // Descriptor fetch sequencer
  typedef enum logic [1:0] {
    FS_IDLE = 2'b01,
    FS_WAIT = 2'b10
  } itxc_fs_t;
endpackage

//--- verilog/itxc_ctx_status.sv
// Status, wake and command pointer logic of eight isochronous transmit contexts
// Behaviour
// - Software sets wake; each fetch clears it
// - Fatal error sets dead; run clear clears
// - Active stays high while processing descriptors
// - Reserved control bits always read zero
// - Final descriptor records completion status code
// - Tolerate seven skipped cycles before fatal
// - Overflow fatal sets dead, timeout, fatal flag
// - Pointer gives first block fetched on run
// - Command pointer is read-only, always readable
// - Eight pointers at 20Ch plus 16n
// - Only software sets or clears run
// - Pointer holds address and count, zero invalid
`timescale 1ns/1ps
`default_nettype none
module itxc_ctx_status (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  // AXI4-Lite slave
  input  wire logic [itxc_pkg::AW-1:0]      s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [itxc_pkg::DW-1:0]      s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [itxc_pkg::AW-1:0]      s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [itxc_pkg::DW-1:0]           s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Descriptor fetch towards host memory
  output logic                              fetch_req,
  output logic [itxc_pkg::DW-1:0]           fetch_addr,
  output logic [itxc_pkg::CTX_W-1:0]        fetch_ctx,
  input  wire logic                         fetch_done,
  input  wire logic                         fetch_err,
  input  wire logic                         fetch_last,
  input  wire logic [itxc_pkg::CODE_W-1:0]  fetch_code,
  input  wire logic [itxc_pkg::DW-1:0]      fetch_next,
  // Transmit overflow, one skipped cycle
  input  wire logic                         ovf_pulse,
  input  wire logic [itxc_pkg::CTX_W-1:0]   ovf_ctx,
  // Interrupt
  output logic                              irq
);
  import itxc_pkg::*;

  // Bus slave state
  logic              aw_full_reg, aw_full_next;   // Write address held
  logic              w_full_reg,  w_full_next;    // Write data held
  logic [AW-1:0]     aw_addr_reg;                 // Held write address
  logic [DW-1:0]     w_data_reg;                  // Held write data
  logic [3:0]        w_strb_reg;                  // Held byte enables
  logic              awready_reg, wready_reg, arready_reg;
  logic              bvalid_reg, bvalid_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [DW-1:0]     rdata_reg;
  // Per-context state
  logic [NCTX-1:0]   run_reg, run_next;
  logic [NCTX-1:0]   wake_reg, wake_next;
  logic [NCTX-1:0]   dead_reg, dead_next;
  logic [NCTX-1:0]   active_reg, active_next;
  logic [CODE_W-1:0] code_reg [NCTX];             // Completion status
  logic [CODE_W-1:0] code_next [NCTX];
  logic [DW-1:0]     ptr_reg [NCTX];              // Command pointer
  logic [DW-1:0]     ptr_next [NCTX];
  logic [SKIP_W-1:0] skip_reg [NCTX];             // Skipped cycles so far
  logic [SKIP_W-1:0] skip_next [NCTX];
  logic [DW-1:0]     ctl_word [NCTX];             // Control read view
  // Per-context events
  logic [NCTX-1:0]   set_run, stop, set_wake, ld_hit, rsp, fatal, ovf_hit, want, done_evt;
  // Event status and mask
  logic [DW-1:0]     stat_reg, stat_next, mask_reg, mask_next;
  logic              irq_reg;
  // Fetch sequencer
  itxc_fs_t          fs_reg, fs_next;
  logic              fetch_req_reg;
  logic [DW-1:0]     fetch_addr_reg;
  logic [CTX_W-1:0]  fetch_ctx_reg;
  logic [CTX_W-1:0]  pick;                        // Context granted next
  logic              any_want;

  // Write path decode
  wire           aw_take   = s_axi_awvalid && awready_reg;
  wire           w_take    = s_axi_wvalid && wready_reg;
  wire           wr_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [DW-1:0]  wmask     = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                              {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [DW-1:0]  wd        = w_data_reg & wmask;
  wire           wr_blk    = aw_addr_reg[AW-1:BLK_LSB] == CTX_BLK;
  wire [CTX_W-1:0] wr_ctx  = aw_addr_reg[CTX_LSB +: CTX_W];
  wire [1:0]     wr_sub    = aw_addr_reg[SUB_LSB +: 2];
  wire           wr_iclr   = aw_addr_reg == A_INT_CLR;
  wire           wr_imask  = aw_addr_reg == A_INT_MASK;
  wire           wr_map    = wr_blk || wr_iclr || wr_imask || aw_addr_reg == A_INT_STAT;
  // Read path decode, on the address as it is taken
  wire           ar_take   = s_axi_arvalid && arready_reg;
  wire           rd_blk    = s_axi_araddr[AW-1:BLK_LSB] == CTX_BLK;
  wire [CTX_W-1:0] rd_ctx  = s_axi_araddr[CTX_LSB +: CTX_W];
  wire [1:0]     rd_sub    = s_axi_araddr[SUB_LSB +: 2];
  wire           rd_stat   = s_axi_araddr == A_INT_STAT || s_axi_araddr == A_INT_CLR;
  wire           rd_mask   = s_axi_araddr == A_INT_MASK;
  wire           rd_map    = rd_blk || rd_stat || rd_mask;
  // Pointer reads are served whatever the context is doing
  wire [DW-1:0]  rd_ctxw   = (rd_sub == SUB_PTR) ? ptr_reg[rd_ctx] :
                             (rd_sub == SUB_LOAD) ? '0 : ctl_word[rd_ctx];
  wire [DW-1:0]  rd_word   = rd_blk ? rd_ctxw : rd_stat ? stat_reg :
                             rd_mask ? mask_reg : '0;
  // Unlisted codes from the transmit side are reported as unknown
  wire           code_ok   = fetch_code == ACK_COMPLETE || fetch_code == EVT_DESC_RD ||
                             fetch_code == EVT_DATA_RD || fetch_code == EVT_TIMEOUT;
  wire [CODE_W-1:0] code_in = code_ok ? fetch_code : EVT_UNKNOWN;
  wire           in_wait   = fs_reg == FS_WAIT;
  wire           issue     = fs_reg == FS_IDLE && any_want;
  wire           next_ok   = fetch_next[Z_W-1:0] != '0;

  // Bus handshake next values; one write and one read in flight
  assign aw_full_next = (aw_full_reg || aw_take) && !wr_fire;
  assign w_full_next  = (w_full_reg || w_take) && !wr_fire;
  assign bvalid_next  = wr_fire || (bvalid_reg && !s_axi_bready);
  assign rvalid_next  = ar_take || (rvalid_reg && !s_axi_rready);

  // Bus slave registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      // Ready stays low until the answer has been taken
      awready_reg <= !aw_full_next && !bvalid_next;
      wready_reg  <= !w_full_next && !bvalid_next;
      arready_reg <= !rvalid_next;
      bvalid_reg  <= bvalid_next;
      rvalid_reg  <= rvalid_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Per-context control, status and pointer
  for (genvar n = 0; n < NCTX; n++) begin : g_ctx
    wire sel    = wr_fire && wr_blk && wr_ctx == CTX_W'(n);
    wire ptr_ok = ptr_reg[n][Z_W-1:0] != '0;
    wire launch;
    assign set_run[n]  = sel && wr_sub == SUB_SET && wd[B_RUN];
    assign stop[n]     = sel && wr_sub == SUB_CLR && wd[B_RUN];
    assign set_wake[n] = sel && wr_sub == SUB_SET && wd[B_WAKE];
    // Pointer loads only while stopped, so a live pointer never jumps
    assign ld_hit[n]   = sel && wr_sub == SUB_LOAD && !run_reg[n];
    assign rsp[n]      = fetch_done && in_wait && fetch_ctx_reg == CTX_W'(n);
    assign ovf_hit[n]  = ovf_pulse && ovf_ctx == CTX_W'(n) && active_reg[n];
    // Eighth skip in a row is fatal
    assign fatal[n]    = (rsp[n] && fetch_err) ||
                         (ovf_hit[n] && skip_reg[n] == SKIP_MAX);
    assign done_evt[n] = rsp[n] && !fetch_err && fetch_last;
    assign want[n]     = active_reg[n] && !stop[n];
    // Start on run going high, or resume on wake while idle
    assign launch      = !active_reg[n] && !dead_reg[n] && ptr_ok &&
                         ((set_run[n] && !run_reg[n]) || (set_wake[n] && run_reg[n]));
    // Run changes only by software writes or reset
    assign run_next[n] = stop[n] ? 1'b0 : (set_run[n] ? 1'b1 : run_reg[n]);
    // Wake set by software wins over the fetch clear
    assign wake_next[n] = set_wake[n] ? 1'b1 :
                          (issue && pick == CTX_W'(n)) ? 1'b0 : wake_reg[n];
    // Fatal set wins over the run-clear that clears dead
    assign dead_next[n] = fatal[n] ? 1'b1 : stop[n] ? 1'b0 : dead_reg[n];
    // Active drops on stop, fatal, or running out of blocks unwoken
    assign active_next[n] = (stop[n] || fatal[n]) ? 1'b0 :
                            (rsp[n] && !next_ok && !wake_reg[n]) ? 1'b0 :
                            launch ? 1'b1 : active_reg[n];
    // Pointer follows each fetched branch; a zero count keeps the last block
    assign ptr_next[n] = ld_hit[n] ? ((ptr_reg[n] & ~wmask) | wd) :
                         (rsp[n] && !fetch_err && next_ok) ? fetch_next : ptr_reg[n];
    assign code_next[n] = (ovf_hit[n] && fatal[n]) ? EVT_TIMEOUT :
                          (rsp[n] && fetch_err) ? EVT_DESC_RD :
                          done_evt[n] ? code_in : code_reg[n];
    assign skip_next[n] = (rsp[n] && !fetch_err) ? '0 :
                          (ovf_hit[n] && !fatal[n]) ? skip_reg[n] + 1'b1 : skip_reg[n];
    // Reserved bits are tied to zero in the read view
    assign ctl_word[n] = {16'h0000, run_reg[n], 2'b00, wake_reg[n],
                          dead_reg[n], active_reg[n], 5'b00000, code_reg[n]};
  end

  // Event status: sets win over write-one clears
  assign stat_next = ((stat_reg & ~((wr_fire && wr_iclr) ? wd : '0))
                     | {7'h00, |fatal, 16'h0000, done_evt}) & INT_DEF;
  assign mask_next = (wr_fire && wr_imask) ? (wd & INT_DEF) : mask_reg;

  // Context and event registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_reg    <= '0;
      wake_reg   <= '0;
      dead_reg   <= '0;
      active_reg <= '0;
      code_reg   <= '{default: '0};
      ptr_reg    <= '{default: '0};
      skip_reg   <= '{default: '0};
      stat_reg   <= '0;
      mask_reg   <= '0;
      irq_reg    <= 1'b0;
    end else begin
      run_reg    <= run_next;
      wake_reg   <= wake_next;
      dead_reg   <= dead_next;
      active_reg <= active_next;
      code_reg   <= code_next;
      ptr_reg    <= ptr_next;
      skip_reg   <= skip_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      irq_reg    <= |(stat_next & mask_next);
    end
  end

  // Fixed priority: lowest context number wins, which can starve high ones
  always_comb begin
    pick     = '0;
    any_want = 1'b0;
    for (int i = NCTX - 1; i >= 0; i--) begin
      if (want[i]) begin
        pick     = CTX_W'(i);
        any_want = 1'b1;
      end
    end
  end

  // Fetch sequencer next state
  always_comb begin
    case (fs_reg)
      FS_IDLE: fs_next = any_want ? FS_WAIT : FS_IDLE;
      FS_WAIT: fs_next = fetch_done ? FS_IDLE : FS_WAIT;
      default: fs_next = FS_IDLE;
    endcase
  end

  // Fetch request held until memory answers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fs_reg         <= FS_IDLE;
      fetch_req_reg  <= 1'b0;
      fetch_addr_reg <= '0;
      fetch_ctx_reg  <= '0;
    end else begin
      fs_reg        <= fs_next;
      fetch_req_reg <= fs_next == FS_WAIT;
      if (issue) begin
        // Block address from the pointer, count bits dropped
        fetch_addr_reg <= {ptr_reg[pick][DW-1:Z_W], {Z_W{1'b0}}};
        fetch_ctx_reg  <= pick;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign fetch_req     = fetch_req_reg;
  assign fetch_addr    = fetch_addr_reg;
  assign fetch_ctx     = fetch_ctx_reg;
  assign irq           = irq_reg;

  // Checks on context 0 stand for all contexts
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_issue0;
    issue && pick == '0 && !set_wake[0];
  endsequence
  sequence s_fetch_open;
    fetch_req && !fetch_done;
  endsequence

  a_wake_fetch_clr:
    assert property (s_issue0 |=> !wake_reg[0] && fetch_req)
    else $error("wake not cleared by fetch");
  a_dead_run_clr:
    assert property (stop[0] && !fatal[0] ##1 !set_run[0] |-> !dead_reg[0] && !run_reg[0])
    else $error("dead not cleared by run clear");
  a_active_stops:
    assert property (fatal[0] |=> !active_reg[0] && dead_reg[0])
    else $error("active stayed after fatal");
  a_rsvd_zero:
    assert property (rvalid_reg && $past(ar_take && rd_blk && rd_sub != SUB_PTR)
                     |-> rdata_reg[14:13] == 2'b00 && rdata_reg[9:5] == 5'b00000)
    else $error("reserved bits read nonzero");
  a_final_code:
    assert property (done_evt[0] && !ovf_hit[0] |=> code_reg[0] == $past(code_in) ##1 stat_reg[0])
    else $error("completion status not recorded");
  a_skip_tolerate:
    assert property (ovf_hit[0] && skip_reg[0] != SKIP_MAX && !rsp[0] && !dead_reg[0]
                     |=> !dead_reg[0])
    else $error("context died before eighth skip");
  a_timeout_fatal:
    assert property (ovf_hit[0] && skip_reg[0] == SKIP_MAX
                     |=> dead_reg[0] && code_reg[0] == EVT_TIMEOUT && stat_reg[B_FATAL])
    else $error("overflow fatal not flagged");
  a_first_block:
    assert property (issue |=> fetch_addr[DW-1:Z_W] == $past(ptr_reg[pick][DW-1:Z_W]))
    else $error("fetch address not from pointer");
  a_ptr_readonly:
    assert property (wr_fire && wr_blk && wr_ctx == '0 && wr_sub == SUB_PTR && !rsp[0]
                     |=> $stable(ptr_reg[0]))
    else $error("pointer changed by a write");
  a_run_soft_only:
    assert property (!set_run[0] && !stop[0] |=> run_reg[0] == $past(run_reg[0]))
    else $error("run changed without software");
  a_fetch_hold:
    assert property (s_fetch_open |=> fetch_req && $stable(fetch_addr) && $stable(fetch_ctx))
    else $error("fetch request dropped early");
endmodule
`default_nettype wire

//--- sim/itxc_mem_model.sv
// Host memory model answering descriptor fetches after a set delay
`timescale 1ns/1ps
`default_nettype none
module itxc_mem_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        fetch_req,
  input  wire logic [7:0]  dly,        // Answer latency in cycles
  input  wire logic        err_in,     // Answer with a read failure
  input  wire logic        last_in,    // Answer marks a final descriptor
  input  wire logic [4:0]  code_in,    // Completion code to return
  input  wire logic [31:0] next_in,    // Next pointer word to return
  output logic             fetch_done,
  output logic             fetch_err,
  output logic             fetch_last,
  output logic [4:0]       fetch_code,
  output logic [31:0]      fetch_next
);
  logic [7:0] cnt_reg; // Cycles waited on the pending request
  // Outside an answer the data lines toggle, so a stale word never looks valid
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
      fetch_done <= 1'b0;
      fetch_err <= 1'b0;
      fetch_last <= 1'b0;
      fetch_code <= 5'h00;
      fetch_next <= 32'h0;
    end else if (fetch_req && !fetch_done && cnt_reg >= dly) begin
      cnt_reg <= 8'h00;
      fetch_done <= 1'b1;
      fetch_err <= err_in;
      fetch_last <= last_in;
      fetch_code <= code_in;
      fetch_next <= next_in;
    end else begin
      cnt_reg <= (fetch_req && !fetch_done) ? cnt_reg + 8'h01 : 8'h00;
      fetch_done <= 1'b0;
      fetch_err <= ~fetch_err;
      fetch_last <= ~fetch_last;
      fetch_code <= ~fetch_code;
      fetch_next <= ~fetch_next;
    end
  end
endmodule
`default_nettype wire

//--- sim/iso_tx_context_status_ptr_test.sv
// Self-checking bench for the transmit context status block
`timescale 1ns/1ps
`default_nettype none
module iso_tx_context_status_ptr_test;
  import itxc_pkg::*;
  logic        clock, reset_n, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, fetch_addr, fetch_next, m_next, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        fetch_req, fetch_done, fetch_err, fetch_last, ovf_pulse, m_err, m_last;
  logic [2:0]  fetch_ctx, ovf_ctx;
  logic [4:0]  fetch_code, m_code;
  logic [7:0]  m_dly;
  int          n_fail = 0, checks_done = 0, cyc = 0;

  itxc_ctx_status DUT (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_addr, .fetch_ctx,
    .fetch_done, .fetch_err, .fetch_last, .fetch_code, .fetch_next, .ovf_pulse, .ovf_ctx,
    .irq);
  itxc_mem_model mem (.clock, .reset_n, .fetch_req, .dly(m_dly), .err_in(m_err),
    .last_in(m_last), .code_in(m_code), .next_in(m_next), .fetch_done, .fetch_err,
    .fetch_last, .fetch_code, .fetch_next);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cut a hang short well beyond the longest expected run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Fetch edges seen on the memory side
  task automatic req_up();
    do @(posedge clock); while (!fetch_req);
  endtask
  task automatic req_down();
    do @(posedge clock); while (fetch_req);
    repeat (4) @(posedge clock);
  endtask

  // Reserved bits, read-only pointer and unmapped places
  task automatic t_regs();
    axi_wr(12'h200, 32'hffff_63e0);
    axi_rd(12'h200);
    chk(rd, 32'h0, "reserved bits");
    axi_wr(12'h208, 32'h0000_a5a1);
    axi_wr(12'h20c, 32'hffff_fff1);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "pointer write answered");
    axi_rd(12'h20c);
    chk(rd, 32'h0000_a5a1, "pointer write ignored");
    axi_wr(12'h100, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(12'h100);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
  endtask

  // Completion codes ACK_COMPLETE, EVT_DATA_RD, EVT_UNKNOWN and an unlisted code, a failed read, then the interrupt path
  task automatic t_codes();
    logic [4:0] cin [5] = '{ACK_COMPLETE, EVT_DATA_RD, EVT_UNKNOWN, 5'h1f, 5'h00};
    logic [4:0] cex [5] = '{ACK_COMPLETE, EVT_DATA_RD, EVT_UNKNOWN, EVT_UNKNOWN, EVT_DESC_RD};
    for (int i = 0; i < 5; i++) begin
      m_err <= (i == 4);
      m_code <= cin[i];
      m_last <= 1'b1;
      m_dly <= 8'h04;
      m_next <= 32'h0000_3000;
      axi_wr(12'h208, 32'h0004_5671);
      axi_wr(12'h200, 32'h0000_8000);
      req_up();
      chk(fetch_addr, 32'h0004_5670, "first block");
      req_down();
      axi_rd(12'h200);
      chk(rd & 32'h0000_8c1f, {16'h0, 4'h8, (i == 4), 6'h0, cex[i]}, "code");
      axi_wr(12'h204, 32'h0000_8000);
    end
    axi_rd(12'h200);
    chk(rd & 32'h0000_8c00, 32'h0, "dead cleared by stop");
    axi_rd(12'h080);
    chk(rd & 32'h1, 32'h1, "done event");
    axi_wr(12'h088, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    axi_wr(12'h084, 32'h0100_00ff);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    axi_wr(12'h088, 32'h0100_0000);
  endtask

  // Wake during a pending fetch forces a refetch that clears it again
  task automatic t_wake();
    m_err <= 1'b0;
    m_last <= 1'b0;
    m_dly <= 8'h1e;
    m_next <= 32'h0000_7000;
    axi_wr(12'h258, 32'h0001_2343);
    axi_rd(12'h25c);
    chk(rd, 32'h0001_2343, "pointer of context 5");
    axi_wr(12'h250, 32'h0000_8000);
    req_up();
    chk({29'h0, fetch_ctx}, 32'h5, "fetch context");
    chk(fetch_addr, 32'h0001_2340, "fetch block");
    axi_wr(12'h250, 32'h0000_1000);
    axi_rd(12'h250);
    chk(rd & 32'h0000_9c00, 32'h0000_9400, "wake while active");
    do @(posedge clock); while (fetch_req);
    req_up();
    axi_rd(12'h250);
    chk(rd & 32'h0000_9c00, 32'h0000_8400, "wake cleared by fetch");
    req_down();
    axi_rd(12'h250);
    chk(rd & 32'h0000_0c00, 32'h0, "stopped");
    axi_rd(12'h25c);
    chk(rd, 32'h0001_2343, "pointer kept on zero count");
    axi_wr(12'h254, 32'h0000_8000);
  endtask

  task automatic skip();
    ovf_ctx <= 3'h0;
    ovf_pulse <= 1'b1;
    @(posedge clock);
    ovf_pulse <= 1'b0;
    @(posedge clock);
  endtask

  // Seven skips tolerated, the eighth is fatal
  task automatic t_ovf();
    m_dly <= 8'h96;
    m_next <= 32'h0000_8001;
    axi_wr(12'h208, 32'h0000_5001);
    axi_wr(12'h200, 32'h0000_8000);
    req_up();
    repeat (7) skip();
    axi_rd(12'h200);
    chk(rd & 32'h0000_8c00, 32'h0000_8400, "seven skips");
    skip();
    axi_rd(12'h200);
    chk(rd & 32'h0000_8c1f, {16'h0, 11'h440, EVT_TIMEOUT}, "eighth skip");
    axi_rd(12'h080);
    chk(rd & 32'h0100_0000, 32'h0100_0000, "fatal flag");
    chk({31'h0, irq}, 32'h1, "fatal irq");
    axi_wr(12'h204, 32'h0000_8000);
    axi_rd(12'h200);
    chk(rd & 32'h0000_8c00, 32'h0, "dead cleared");
    req_down();
    axi_rd(12'h20c);
    chk(rd, 32'h0000_8001, "pointer follows branch");
  endtask

  initial begin
    reset_n = 1'b0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ovf_pulse, m_err, m_last, ovf_ctx, m_code, m_dly} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, m_next} = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_regs();
    t_codes();
    t_wake();
    t_ovf();
    close_out();
  end
endmodule
`default_nettype wire
